// ===== iomq_unit.v
// message queue unit: four address queues in local memory
// Behaviour
// - four circular queues of frame addresses kept in local memory
// - top and bottom pointer per queue, offsets from 1 Mbyte aligned base
// - add stores at top pointer, remove takes from bottom pointer
// - pci write to inbound port posts to inbound post queue, local interrupt if enabled
// - pci read of inbound port pops inbound free queue, all ones if empty
// - pci read of outbound port pops outbound post queue, all ones if empty
// - pci write to outbound port stores at top of outbound free queue
// - local post into outbound post queue raises pci interrupt unless masked
// - with messaging enabled image zero base at 0x010, register base at 0x018
// - lowest 4 Kbytes untranslated; higher accesses go through image zero
// - offsets 0x030 and 0x034 decode as system interrupt generation
// - upper twelve address bits come from base field for all pointers
// - size code zero means 256 entries, used for pointer wrap
// - equal pointers mean empty; software marks full by top wrapping to bottom
// - each outbound port write with messaging enabled advances outbound free top by four unless the outbound free queue is full
// - unit advances four pointers by four, wrapping modulo queue size
// - top not advanced when full, bottom not advanced when empty
// - writing one to inbound post new status clears it and local interrupt
// - outbound post status clears when a pci read empties the queue
`timescale 1ns/1ps
`include "iomq_defs.vh"
module iomq_unit (
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        pci_req_i,
	input  wire        pci_we_i,
	input  wire [31:0] pci_addr_i,
	input  wire [31:0] pci_wdata_i,
	output reg         pci_ack_o,
	output reg         pci_fwd_o,
	output wire        rsp_valid_o,
	input  wire        rsp_ready_i,
	output wire [31:0] rsp_data_o,
	input  wire        lcl_wr_i,
	input  wire        lcl_rd_i,
	input  wire [3:0]  lcl_addr_i,
	input  wire [31:0] lcl_wdata_i,
	output reg  [31:0] lcl_rdata_o,
	output reg         mem_req_o,
	output reg         mem_we_o,
	output reg  [31:0] mem_addr_o,
	output reg  [31:0] mem_wdata_o,
	input  wire        mem_ack_i,
	input  wire [31:0] mem_rdata_i,
	output reg         lcl_int_o,
	output reg         pci_int_o,
	output reg  [1:0]  sys_int_o,
	output reg         cfg_bar0_image0_o,
	output reg  [7:0]  cfg_regspace_bar_o
);
	// =========================================================
	// state and storage
	localparam ST_IDLE = 2'd0;
	localparam ST_MEM  = 2'd1;
	localparam ST_DONE = 2'd2;

	reg [1:0]  st_r;
	reg [31:0] ctrl_r;
	reg [19:0] ptr_r [0:7];
	reg [3:0]  full_r;
	reg        ipn_st_r;
	reg        op_st_r;
	reg [2:0]  op_ptr_r;
	reg        op_rd_r;
	reg        push_r;
	reg [31:0] push_data_r;
	wire       buf_ready;
	wire [3:0] empty;
	wire       ipn_clr;
	wire       lcl_ptr_wr;
	wire [2:0] lcl_pidx;
	wire [1:0] lcl_q;
	wire       full_mark;
	wire       op_top_wr;
	wire [19:0] op_top_next;
	integer    k;

	// =========================================================
	// helpers
	// next pointer: step one entry, wrap within the queue size
	function [19:0] ptr_step;
		input [19:0] p;
		input [2:0]  sz;
		reg   [19:0] msk;
		begin
			msk      = (`IOMQ_QBYTES_MIN << sz) - 20'h0_0001;
			ptr_step = (p & ~msk) | ((p + `IOMQ_ENTRY_BYTES) & msk);
		end
	endfunction

	// full local address from base field and pointer
	function [31:0] ptr_addr;
		input [11:0] base;
		input [19:0] p;
		begin
			ptr_addr = {base, p};
		end
	endfunction

	// local index selects one of the eight pointer registers
	function is_ptr_idx;
		input [3:0] a;
		begin
			is_ptr_idx = (a >= `IOMQ_REG_PTR0) && (a < `IOMQ_REG_STAT);
		end
	endfunction

	wire [2:0]  qsize = ctrl_r[`IOMQ_CTRL_SIZE_LO+2:`IOMQ_CTRL_SIZE_LO];
	wire [11:0] qbase = ctrl_r[31:`IOMQ_CTRL_BASE_LO];
	wire        msg_en = ctrl_r[`IOMQ_CTRL_EN_BIT];

	genvar q;
	generate
		for (q = 0; q < 4; q = q + 1) begin : g_empty
			assign empty[q] = (ptr_r[2*q] == ptr_r[2*q+1]) && !full_r[q];
		end
	endgenerate

	// =========================================================
	// answer buffer
	iomq_buf2 #(
		.W (32)
	) u_buf (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (push_r),
		.in_ready_o  (buf_ready),
		.in_data_i   (push_data_r),
		.out_valid_o (rsp_valid_o),
		.out_ready_i (rsp_ready_i),
		.out_data_o  (rsp_data_o)
	);

	assign ipn_clr = lcl_wr_i && (lcl_addr_i == `IOMQ_REG_STAT) && lcl_wdata_i[`IOMQ_STAT_IPN_BIT];

	// pointer decode; equal pointers stay empty unless the top write steps onto bottom
	assign lcl_ptr_wr  = lcl_wr_i && is_ptr_idx(lcl_addr_i);
	assign lcl_pidx    = lcl_addr_i[2:0] - 3'd1;
	assign lcl_q       = lcl_pidx[2:1];
	assign full_mark   = (lcl_wdata_i[19:0] == ptr_r[lcl_pidx - 3'd1]) &&
	                     (lcl_wdata_i[19:0] == ptr_step(ptr_r[lcl_pidx], qsize));
	assign op_top_wr   = lcl_ptr_wr && (lcl_pidx == `IOMQ_P_OP_TOP);
	assign op_top_next = op_top_wr ? lcl_wdata_i[19:0] : ptr_r[`IOMQ_P_OP_TOP];

	// =========================================================
	// main sequencer, pointers and flags
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_r        <= ST_IDLE;
			ctrl_r      <= `IOMQ_CTRL_RESET;
			full_r      <= 4'h0;
			ipn_st_r    <= 1'b0;
			op_st_r     <= 1'b0;
			op_ptr_r    <= 3'd0;
			op_rd_r     <= 1'b0;
			push_r      <= 1'b0;
			push_data_r <= 32'h0000_0000;
			pci_ack_o   <= 1'b0;
			pci_fwd_o   <= 1'b0;
			sys_int_o   <= 2'b00;
			mem_req_o   <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_addr_o  <= 32'h0000_0000;
			mem_wdata_o <= 32'h0000_0000;
			for (k = 0; k < 8; k = k + 1)
				ptr_r[k] <= 20'h0_0000;
		end else begin
			push_r    <= 1'b0;
			pci_ack_o <= 1'b0;
			pci_fwd_o <= 1'b0;
			sys_int_o <= 2'b00;
			// local register writes
			if (lcl_wr_i) begin
				if (lcl_addr_i == `IOMQ_REG_CTRL)
					ctrl_r <= lcl_wdata_i;
				if (lcl_ptr_wr) begin
					ptr_r[lcl_pidx] <= lcl_wdata_i[19:0];
					if (lcl_pidx[0]) // top written
						full_r[lcl_q] <= full_mark;
					else
						full_r[lcl_q] <= 1'b0;
					if (op_top_wr && (lcl_wdata_i[19:0] != ptr_r[`IOMQ_P_OP_BOT]))
						op_st_r <= 1'b1;
				end
			end
			if (ipn_clr)
				ipn_st_r <= 1'b0;
			case (st_r)
			ST_IDLE: begin
				// the edge that samples ack still sees the finished request: skip it
				if (pci_req_i && buf_ready && !pci_ack_o) begin
					st_r <= ST_DONE;
					if (pci_addr_i > `IOMQ_UNXLATE_TOP) begin
						pci_fwd_o <= 1'b1;
					end else if (pci_we_i) begin
						if (pci_addr_i == `IOMQ_OFF_SYSINT0)
							sys_int_o <= 2'b01;
						else if (pci_addr_i == `IOMQ_OFF_SYSINT1)
							sys_int_o <= 2'b10;
						else if (msg_en && (pci_addr_i == `IOMQ_OFF_IN_QUEUE) && !full_r[1]) begin
							op_ptr_r    <= `IOMQ_P_IP_TOP;
							mem_addr_o  <= ptr_addr(qbase, ptr_r[`IOMQ_P_IP_TOP]);
							mem_wdata_o <= pci_wdata_i;
							mem_we_o    <= 1'b1;
							mem_req_o   <= 1'b1;
							op_rd_r     <= 1'b0;
							st_r        <= ST_MEM;
						end else if (msg_en && (pci_addr_i == `IOMQ_OFF_OUT_QUEUE) && !full_r[3]) begin
							op_ptr_r    <= `IOMQ_P_OF_TOP;
							mem_addr_o  <= ptr_addr(qbase, ptr_r[`IOMQ_P_OF_TOP]);
							mem_wdata_o <= pci_wdata_i;
							mem_we_o    <= 1'b1;
							mem_req_o   <= 1'b1;
							op_rd_r     <= 1'b0;
							st_r        <= ST_MEM;
						end
					end else begin
						if (msg_en && (pci_addr_i == `IOMQ_OFF_IN_QUEUE) && !empty[0]) begin
							op_ptr_r   <= `IOMQ_P_IF_BOT;
							mem_addr_o <= ptr_addr(qbase, ptr_r[`IOMQ_P_IF_BOT]);
							mem_we_o   <= 1'b0;
							mem_req_o  <= 1'b1;
							op_rd_r    <= 1'b1;
							st_r       <= ST_MEM;
						end else if (msg_en && (pci_addr_i == `IOMQ_OFF_OUT_QUEUE) && !empty[2]) begin
							op_ptr_r   <= `IOMQ_P_OP_BOT;
							mem_addr_o <= ptr_addr(qbase, ptr_r[`IOMQ_P_OP_BOT]);
							mem_we_o   <= 1'b0;
							mem_req_o  <= 1'b1;
							op_rd_r    <= 1'b1;
							st_r       <= ST_MEM;
						end else begin
							push_r <= 1'b1;
							if ((pci_addr_i == `IOMQ_OFF_IN_QUEUE) || (pci_addr_i == `IOMQ_OFF_OUT_QUEUE))
								push_data_r <= `IOMQ_EMPTY_WORD;
							else
								push_data_r <= 32'h0000_0000;
						end
					end
				end
			end
			ST_MEM: begin
				if (mem_ack_i) begin
					mem_req_o <= 1'b0;
					mem_we_o  <= 1'b0;
					st_r      <= ST_DONE;
					ptr_r[op_ptr_r] <= ptr_step(ptr_r[op_ptr_r], qsize);
					if (op_rd_r) begin
						push_r      <= 1'b1;
						push_data_r <= mem_rdata_i;
						full_r[op_ptr_r[2:1]] <= 1'b0;
						// a post in the same cycle keeps the status set
						if ((op_ptr_r == `IOMQ_P_OP_BOT) && (ptr_step(ptr_r[op_ptr_r], qsize) == op_top_next))
							op_st_r <= 1'b0;
					end else begin
						if (ptr_step(ptr_r[op_ptr_r], qsize) == ptr_r[op_ptr_r - 3'd1])
							full_r[op_ptr_r[2:1]] <= 1'b1;
						if (op_ptr_r == `IOMQ_P_IP_TOP)
							ipn_st_r <= 1'b1; // set wins over clear
					end
				end
			end
			ST_DONE: begin
				pci_ack_o <= 1'b1;
				st_r      <= ST_IDLE;
			end
			default: begin
				st_r <= ST_IDLE;
			end
			endcase
		end
	end

	// =========================================================
	// local read, interrupts and configuration view
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			lcl_rdata_o        <= 32'h0000_0000;
			lcl_int_o          <= 1'b0;
			pci_int_o          <= 1'b0;
			cfg_bar0_image0_o  <= 1'b0;
			cfg_regspace_bar_o <= `IOMQ_CFG_BAR_FIRST;
		end else begin
			lcl_int_o          <= ipn_st_r && ctrl_r[`IOMQ_CTRL_IPN_EN_BIT];
			pci_int_o          <= op_st_r && !ctrl_r[`IOMQ_CTRL_OPMSK_BIT];
			cfg_bar0_image0_o  <= msg_en;
			cfg_regspace_bar_o <= msg_en ? `IOMQ_CFG_BAR_MOVED : `IOMQ_CFG_BAR_FIRST;
			if (lcl_rd_i) begin
				if (lcl_addr_i == `IOMQ_REG_CTRL)
					lcl_rdata_o <= ctrl_r;
				else if (is_ptr_idx(lcl_addr_i))
					lcl_rdata_o <= ptr_addr(qbase, ptr_r[lcl_addr_i[2:0] - 3'd1]);
				else if (lcl_addr_i == `IOMQ_REG_STAT)
					lcl_rdata_o <= {20'h0_0000, full_r, empty, 2'b00, op_st_r, ipn_st_r};
				else
					lcl_rdata_o <= 32'h0000_0000;
			end
		end
	end
endmodule // iomq_unit

// ===== iomq_defs.vh
// constants for the io message queue unit
`ifndef IOMQ_DEFS_VH
`define IOMQ_DEFS_VH

// pci window offsets
`define IOMQ_OFF_SYSINT0     32'h0000_0030
`define IOMQ_OFF_SYSINT1     32'h0000_0034
`define IOMQ_OFF_IN_QUEUE    32'h0000_0040
`define IOMQ_OFF_OUT_QUEUE   32'h0000_0044
`define IOMQ_UNXLATE_TOP     32'h0000_0fff
`define IOMQ_EMPTY_WORD      32'h ffff_ffff

// configuration base address slots
`define IOMQ_CFG_BAR_FIRST   8'h10
`define IOMQ_CFG_BAR_MOVED   8'h18

// local register indexes
`define IOMQ_REG_CTRL        4'h0
`define IOMQ_REG_PTR0        4'h1
`define IOMQ_REG_STAT        4'h9

// control register fields
`define IOMQ_CTRL_EN_BIT     0
`define IOMQ_CTRL_SIZE_LO    1
`define IOMQ_CTRL_IPN_EN_BIT 4
`define IOMQ_CTRL_OPMSK_BIT  5
`define IOMQ_CTRL_BASE_LO    20
`define IOMQ_CTRL_RESET      32'h0000_0000

// status register fields
`define IOMQ_STAT_IPN_BIT    0
`define IOMQ_STAT_OP_BIT     1
`define IOMQ_STAT_EMPTY_LO   4
`define IOMQ_STAT_FULL_LO    8

// queue size: 256 entries of four bytes at size code zero
`define IOMQ_QBYTES_MIN      20'h0_0400
`define IOMQ_ENTRY_BYTES     20'h0_0004

// pointer indexes: bottom then top for each queue
`define IOMQ_P_IF_BOT        3'd0
`define IOMQ_P_IF_TOP        3'd1
`define IOMQ_P_IP_BOT        3'd2
`define IOMQ_P_IP_TOP        3'd3
`define IOMQ_P_OP_BOT        3'd4
`define IOMQ_P_OP_TOP        3'd5
`define IOMQ_P_OF_BOT        3'd6
`define IOMQ_P_OF_TOP        3'd7

`endif

// ===== iomq_buf2.v
// two-entry buffer for read answers
`timescale 1ns/1ps
module iomq_buf2 #(
	parameter W = 32
) (
	input  wire         clk_i,
	input  wire         rst_b_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] ent0_r;
	reg [W-1:0] ent1_r;
	reg [1:0]   cnt_r;
	reg         vld_r;
	wire        push;
	wire        pop;

	assign in_ready_o  = (cnt_r != 2'd2);
	assign out_valid_o = vld_r;
	assign out_data_o  = ent0_r;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			cnt_r  <= 2'd0;
			vld_r  <= 1'b0;
			ent0_r <= {W{1'b0}};
			ent1_r <= {W{1'b0}};
		end else begin
			case ({push, pop})
			2'b10: begin
				if (cnt_r == 2'd0)
					ent0_r <= in_data_i;
				else
					ent1_r <= in_data_i;
				cnt_r <= cnt_r + 2'd1;
				vld_r <= 1'b1;
			end
			2'b01: begin
				ent0_r <= ent1_r;
				cnt_r  <= cnt_r - 2'd1;
				vld_r  <= (cnt_r == 2'd2);
			end
			2'b11: begin
				if (cnt_r == 2'd1)
					ent0_r <= in_data_i;
				else begin
					ent0_r <= ent1_r;
					ent1_r <= in_data_i;
				end
			end
			default: begin
				cnt_r <= cnt_r;
			end
			endcase
		end
	end
endmodule // iomq_buf2

// ===== iomq_unit_asserts.sv
// checker for the message queue unit ports
`timescale 1ns/1ps
module iomq_unit_asserts (
	input wire        clk_i,
	input wire        rst_b_i,
	input wire        pci_req_i,
	input wire        pci_we_i,
	input wire [31:0] pci_addr_i,
	input wire        pci_ack_o,
	input wire        pci_fwd_o,
	input wire        rsp_valid_o,
	input wire        rsp_ready_i,
	input wire [31:0] rsp_data_o,
	input wire        mem_req_o,
	input wire        mem_ack_i,
	input wire [31:0] mem_addr_o,
	input wire        lcl_int_o,
	input wire        pci_int_o,
	input wire [1:0]  sys_int_o,
	input wire        cfg_bar0_image0_o,
	input wire [7:0]  cfg_regspace_bar_o
);
	// ==========
	// port relations
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	regspace_sel_a: assert property (cfg_regspace_bar_o == (cfg_bar0_image0_o ? 8'h18 : 8'h10))
		else $error("register space slot wrong");
	fwd_addr_a: assert property (pci_fwd_o |-> pci_addr_i[31:12] != 20'h0)
		else $error("forward below window top");
	sysint_addr_a: assert property (sys_int_o != 2'b00 |-> pci_we_i && pci_addr_i == (sys_int_o[1] ? 32'h34 : 32'h30))
		else $error("system interrupt from wrong offset");
	ack_pulse_a: assert property (pci_ack_o |=> !pci_ack_o)
		else $error("ack longer than one cycle");
	ack_bound_a: assert property ($rose(pci_req_i) |-> ##[1:60] pci_ack_o)
		else $error("request never acked");
	mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("memory request dropped");
	rsp_hold_a: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o))
		else $error("answer lost in stall");
	lint_ack_a: assert property ($rose(lcl_int_o) |-> pci_ack_o)
		else $error("local interrupt without posting");
	cover property (pci_fwd_o);
	cover property (sys_int_o[1]);
	cover property ($rose(pci_int_o));
endmodule // iomq_unit_asserts

bind iomq_unit iomq_unit_asserts i_iomq_unit_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i), .pci_req_i(pci_req_i),
	.pci_we_i(pci_we_i), .pci_addr_i(pci_addr_i), .pci_ack_o(pci_ack_o), .pci_fwd_o(pci_fwd_o),
	.rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .rsp_data_o(rsp_data_o), .mem_req_o(mem_req_o),
	.mem_ack_i(mem_ack_i), .mem_addr_o(mem_addr_o), .lcl_int_o(lcl_int_o), .pci_int_o(pci_int_o),
	.sys_int_o(sys_int_o), .cfg_bar0_image0_o(cfg_bar0_image0_o), .cfg_regspace_bar_o(cfg_regspace_bar_o));

// ===== iomq_mem_model.sv
// local memory model answering the unit's memory requests
`timescale 1ns/1ps
module iomq_mem_model #(
	parameter SLOW_WAIT = 3
) (
	input  wire        clk_i,
	input  wire        slow_i,
	input  wire        req_i,
	input  wire        we_i,
	input  wire [31:0] addr_i,
	input  wire [31:0] wdata_i,
	output reg         ack_o = 1'b0,
	output reg  [31:0] rdata_o = 32'h0
);
	// ==========
	// word store with prompt or slow answer
	logic [31:0] mem [0:4095];
	int          wait_n = 0;
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (req_i && !ack_o) begin
			if (wait_n < (slow_i ? SLOW_WAIT : 0)) begin
				wait_n <= wait_n + 1;
			end else begin
				wait_n <= 0;
				ack_o <= 1'b1;
				if (we_i) mem[addr_i[13:2]] <= wdata_i;
				else rdata_o <= mem[addr_i[13:2]];
			end
		end
	end
endmodule // iomq_mem_model

// ===== iomq_unit_bench.sv
// testbench for the message queue unit
`timescale 1ns/1ps
`include "iomq_defs.vh"
module iomq_unit_bench;
	logic        clk_i = 1'b0, rst_b_i = 1'b0, slow = 1'b0;
	logic        pci_req_i = 1'b0, pci_we_i = 1'b0, rsp_ready_i = 1'b1;
	logic [31:0] pci_addr_i = 32'h0, pci_wdata_i = 32'h0, lcl_wdata_i = 32'h0;
	logic        lcl_wr_i = 1'b0, lcl_rd_i = 1'b0;
	logic [3:0]  lcl_addr_i = 4'h0;
	wire         pci_ack_o, pci_fwd_o, rsp_valid_o, mem_req_o, mem_we_o, mem_ack_i, lcl_int_o, pci_int_o;
	wire  [31:0] rsp_data_o, lcl_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
	wire  [1:0]  sys_int_o;
	wire         cfg_bar0_image0_o;
	wire  [7:0]  cfg_regspace_bar_o;
	logic [31:0] rq [$];
	logic [2:0]  seen = 3'h0;
	logic [31:0] qin = `IOMQ_OFF_IN_QUEUE, qout = `IOMQ_OFF_OUT_QUEUE, emp = `IOMQ_EMPTY_WORD;
	int          bad_count = 0, tests_run = 0;

	iomq_unit i_iomq_unit (.clk_i(clk_i), .rst_b_i(rst_b_i), .pci_req_i(pci_req_i), .pci_we_i(pci_we_i),
		.pci_addr_i(pci_addr_i), .pci_wdata_i(pci_wdata_i), .pci_ack_o(pci_ack_o), .pci_fwd_o(pci_fwd_o),
		.rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .rsp_data_o(rsp_data_o), .lcl_wr_i(lcl_wr_i),
		.lcl_rd_i(lcl_rd_i), .lcl_addr_i(lcl_addr_i), .lcl_wdata_i(lcl_wdata_i), .lcl_rdata_o(lcl_rdata_o),
		.mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .lcl_int_o(lcl_int_o), .pci_int_o(pci_int_o),
		.sys_int_o(sys_int_o), .cfg_bar0_image0_o(cfg_bar0_image0_o), .cfg_regspace_bar_o(cfg_regspace_bar_o));
	iomq_mem_model i_iomq_mem_model (.clk_i(clk_i), .slow_i(slow), .req_i(mem_req_o), .we_i(mem_we_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) if (rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1) rq.push_back(rsp_data_o);
	always @(posedge clk_i) if (rst_b_i) seen <= seen | {pci_fwd_o, sys_int_o};

	// ==========
	// access tasks
	task automatic results();
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic hang();
		bad_count++;
		$display("[ERR] %0t wait ran out", $time);
		results();
	endtask
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pci(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		@(posedge clk_i);
		pci_req_i <= 1'b1;
		pci_we_i <= w;
		pci_addr_i <= a;
		pci_wdata_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (pci_ack_o !== 1'b1 && n < 60);
		pci_req_i <= 1'b0;
		if (n >= 60) hang();
	endtask
	task automatic prd(input logic [31:0] a, exp);
		pci(1'b0, a, 32'h0);
		for (int n = 0; n < 8 && rq.size() == 0; n++) @(posedge clk_i);
		if (rq.size() == 0) hang();
		chk(rq.pop_front(), exp);
	endtask
	task automatic lw(input logic [3:0] i, input logic [31:0] d);
		@(posedge clk_i);
		lcl_wr_i <= 1'b1;
		lcl_addr_i <= i;
		lcl_wdata_i <= d;
		@(posedge clk_i);
		lcl_wr_i <= 1'b0;
	endtask
	task automatic lr(input logic [3:0] i, input logic [31:0] exp);
		@(posedge clk_i);
		lcl_rd_i <= 1'b1;
		lcl_addr_i <= i;
		@(posedge clk_i);
		lcl_rd_i <= 1'b0;
		@(posedge clk_i);
		chk(lcl_rdata_o, exp);
	endtask

	// ==========
	// main sequence
	initial begin
		i_iomq_mem_model.mem[0] = 32'h2000;
		i_iomq_mem_model.mem[1] = 32'h3000;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		chk({24'h0, cfg_regspace_bar_o}, 32'h10);
		prd(qin, emp);
		for (int i = 0; i < 8; i++) lw(4'(i + 1), 32'(32'h800 * (i / 2) + ((i == 1) ? 8 : 0)));
		lw(`IOMQ_REG_CTRL, 32'ha000_0011);
		repeat (2) @(posedge clk_i);
		chk({24'h0, cfg_regspace_bar_o}, 32'h18);
		chk({31'h0, cfg_bar0_image0_o}, 32'h1);
		prd(qin, 32'h2000);
		slow <= 1'b1;
		prd(qin, 32'h3000);
		prd(qin, emp);
		lr(4'h1, 32'ha000_0008);
		pci(1'b1, qin, 32'h4000);
		chk(i_iomq_mem_model.mem[12'h200], 32'h4000);
		chk({31'h0, lcl_int_o}, 32'h1);
		lr(4'h4, 32'ha000_0804);
		lw(`IOMQ_REG_STAT, 32'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, lcl_int_o}, 32'h0);
		pci(1'b1, qout, 32'h5000);
		chk(i_iomq_mem_model.mem[12'h600], 32'h5000);
		lr(4'h8, 32'ha000_1804);
		i_iomq_mem_model.mem[12'h400] = 32'h6000;
		lw(4'h6, 32'h1004);
		repeat (2) @(posedge clk_i);
		chk({31'h0, pci_int_o}, 32'h1);
		prd(qout, 32'h6000);
		repeat (2) @(posedge clk_i);
		chk({31'h0, pci_int_o}, 32'h0);
		prd(qout, emp);
		lr(4'h5, 32'ha000_1004);
		lw(4'h4, 32'hbfc);
		lw(4'h3, 32'hbfc);
		pci(1'b1, qin, 32'h4400);
		chk(i_iomq_mem_model.mem[12'h2ff], 32'h4400);
		lr(4'h4, 32'ha000_0800);
		lw(4'h8, 32'h1bfc);
		lw(4'h8, 32'h1800);
		pci(1'b1, qout, 32'h7000);
		chk(i_iomq_mem_model.mem[12'h600], 32'h5000);
		lr(4'h8, 32'ha000_1800);
		lr(4'h9, 32'h0000_0851);
		pci(1'b1, 32'h30, 32'h0);
		pci(1'b1, 32'h34, 32'h0);
		chk({29'h0, seen}, 32'h3);
		prd(32'h50, 32'h0);
		pci(1'b1, 32'h2000, 32'h1);
		chk({29'h0, seen}, 32'h7);
		rsp_ready_i <= 1'b0;
		pci(1'b0, qout, 32'h0);
		pci(1'b0, qin, 32'h0);
		chk({31'h0, rsp_valid_o}, 32'h1);
		rsp_ready_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(32'(rq.size()), 32'h2);
		chk(rq.pop_front(), emp);
		chk(rq.pop_front(), emp);
		results();
	end
endmodule // iomq_unit_bench
